// >>> eirr_regs.vh
`ifndef EIRR_REGS_VH
`define EIRR_REGS_VH
// Behaviour
// [RL1] Ch4 pin: 00 pin3, 01 pin4, others prohibited
// [RL2] Ch4 extra use: none, T1 count, T0L/T0H capture
// [RL3] Ch4 capture source masks port-7 capture events
// [RL4] T1 low counts ch4 events else every 2 cycles
// [RL5] Ch1 on pin7: fall, low, rise, high
// [RL6] Ch0 on port-7 pin: fall, low, rise, high
// [RL7] Ch1 flag bit5, enable bit4: HOLD release, vector 000BH
// [RL8] Ch0 flag bit1, enable bit0: HOLD release, vector 0003H
// [RL9] Flags clear only by software write
// [RL10] Ch3/ch2 edge controls: none, fall, rise, both
// [RL11] Ch3 requests vector 001BH, no HOLD release
// [RL12] Ch2 flag bit1: HOLD release, vector 0013H
// [RL13] Ch2 in HOLD ignores edge toward entry level
// [RL14] T0H capture from ch1 or ch3
// [RL15] T0L capture from ch0 or ch2
// [RL16] Base timer clock source select, four choices
// [RL17] Buzzer select steers pin7 buzzer or PWM
// [RL18] Ch3 noise filter: 1, 128, 1, 32 cycles
// [RL19] T0 count clock from ch3 or ch2
// [RL20] Port-7 and pin4 capture conflict masks both; code masks only the port-7/port-1 sources, ch4 still captures
// [RL21] Ch4 edge controls: none, fall, rise, both
// [RL22] Ch4 flag: HOLD release, vector 0013H, HOLD masking
// [RL23] Sample pins per cycle; level mode re-sets
`define EIRR_ADDR_W      16
`define EIRR_OFS_CR01    16'hFE5D
`define EIRR_OFS_CR23    16'hFE5E
`define EIRR_OFS_ISL     16'hFE5F
`define EIRR_OFS_CR45    16'hFE4A
`define EIRR_OFS_SL45    16'hFE4B
`define EIRR_RST         8'h00
`define EIRR_VEC_CH0     16'h0003
`define EIRR_VEC_CH1     16'h000B
`define EIRR_VEC_CH24    16'h0013
`define EIRR_VEC_CH3     16'h001B
`define EIRR_B_HI_MODE   7
`define EIRR_B_HI_SUB    6
`define EIRR_B_HI_FLAG   5
`define EIRR_B_HI_EN     4
`define EIRR_B_LO_MODE   3
`define EIRR_B_LO_SUB    2
`define EIRR_B_LO_FLAG   1
`define EIRR_B_LO_EN     0
`define EIRR_B_CAPH      7
`define EIRR_B_CAPL      6
`define EIRR_B_BUZ       3
`define EIRR_B_FILTER_CONST_SEL     2
`define EIRR_B_FILTER_ON      1
`define EIRR_B_CNT       0
`define EIRR_F4_NONE     2'h0
`define EIRR_F4_T1CNT    2'h1
`define EIRR_F4_CAPL     2'h2
`define EIRR_F4_CAPH     2'h3
`define EIRR_P4_PIN3     2'h0
`define EIRR_P4_PIN4     2'h1
`define EIRR_NF_LONG     8'd128
`define EIRR_NF_SHORT    8'd32
`define EIRR_T1_DIV      1'b1
`endif

// >>> eirr_noise_filter.v
`include "eirr_regs.vh"
module eirr_noise_filter #(
    parameter CW = 8
) (
    input  wire          clk,    // Cycle clock
    input  wire          rstn,   // Async reset
    input  wire          ce,     // Clock enable
    input  wire          din,    // Synchronised input
    input  wire [CW-1:0] span,   // Stable cycles required
    output reg           dout    // Filtered level
);
    reg [CW-1:0] cnt_reg;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= {CW{1'b0}};
            dout    <= 1'b0;
        end else if (ce) begin
            if (din == dout)
                cnt_reg <= {CW{1'b0}};
            else if (cnt_reg + 1'b1 >= span) begin
                dout    <= din;
                cnt_reg <= {CW{1'b0}};
            end else
                cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule // eirr_noise_filter

// >>> eirr_router.v
// Decided for this implementation: register access over Avalon-MM.
`include "eirr_regs.vh"
module eirr_router (
    input  wire        clk,              // Cycle clock, 25 MHz
    input  wire        rstn,             // Async reset, active low
    input  wire        ce,               // Clock enable
    input  wire [15:0] address,          // Avalon byte address
    input  wire        read,             // Avalon read
    input  wire        write,            // Avalon write
    input  wire [7:0]  writedata,        // Avalon write data
    output reg  [7:0]  readdata,         // Avalon read data
    output wire        waitrequest,      // Avalon wait
    input  wire        port1Pin3,        // Pin, async
    input  wire        port1Pin4,        // Pin, async
    input  wire        port1Pin5,        // Pin, async
    input  wire        port1Pin6,        // Pin, async
    input  wire        port1Pin7,        // Pin, async
    input  wire        port7Pin0,        // Pin, async
    input  wire        holdMode,         // CPU in HOLD
    input  wire        subClk,           // Base timer source 0
    input  wire        lowRcClk,         // Base timer source 2
    input  wire        t0PrescOut,       // Base timer source 3
    input  wire        baseDivided,      // Divided base timer clock
    input  wire        timer1HighPwmIn,  // Raw timer 1 high PWM
    input  wire        pin17FuncCtrl,    // Pin 7 function control
    output wire        baseTimerClk,     // Base timer input clock
    output reg         buzzerOut,        // Buzzer output
    output reg         timer1HighPwm,    // Gated PWM
    output reg         pin17AltData,     // Alt data to pin 7
    output wire        holdRelease,      // HOLD release request
    output wire        irqReq,           // Any interrupt request
    output reg  [15:0] irqVector,        // Highest-priority vector
    output reg         t0CapLow,         // T0 low capture pulse
    output reg         t0CapHigh,        // T0 high capture pulse
    output reg         t0CountClk,       // T0 count pulse
    output reg         t1LowTick         // T1 low advance pulse
);
    reg [7:0] cr01Reg, cr23Reg, islReg, cr45Reg, sl45Reg;
    reg [5:0] sync1Reg, sync2Reg;
    reg [4:0] prevReg;
    reg       hold2Lvl, hold4Lvl, holdPrevReg;
    reg       t1DivReg, ackReg;
    reg [7:0] nfSpan;
    wire      ch3Filt;
    wire      p3 = sync2Reg[0], p4 = sync2Reg[1], p5 = sync2Reg[2];
    wire      p6 = sync2Reg[3], p7 = sync2Reg[4], p70 = sync2Reg[5];
    wire      ch4Pin;
    wire      det0, det1, det2, det3, det4;

    // Polarity/level-edge decode for ch0/ch1
    function lvlDet;
        input pol, lvl, cur, prev;
        begin
            if (lvl)
                lvlDet = (cur == pol);                                     // [RL23]
            else
                lvlDet = pol ? (cur & ~prev) : (~cur & prev);
        end
    endfunction
    // Rise/fall enable decode, with HOLD entry-level masking
    function edgDet;
        input rise, fall, cur, prev, inHold, entry;
        begin
            edgDet = (rise & cur & ~prev & ~(inHold & entry))
                   | (fall & ~cur & prev & ~(inHold & ~entry));
        end
    endfunction

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1Reg <= 6'h00;
            sync2Reg <= 6'h00;
        end else if (ce) begin
            sync1Reg <= {port7Pin0, port1Pin7, port1Pin6, port1Pin5, port1Pin4, port1Pin3};
            sync2Reg <= sync1Reg;
        end
    end

    always @* begin
        if (islReg[`EIRR_B_FILTER_ON])                                          // [RL18]
            nfSpan = islReg[`EIRR_B_FILTER_CONST_SEL] ? `EIRR_NF_SHORT : `EIRR_NF_LONG;
        else
            nfSpan = 8'h01;
    end
    eirr_noise_filter #(.CW(8)) uNf (
        .clk (clk),
        .rstn(rstn),
        .ce  (ce),
        .din (p5),
        .span(nfSpan),
        .dout(ch3Filt)
    );

    // Prohibited codes fall back to pin3
    assign ch4Pin = (sl45Reg[3:2] == `EIRR_P4_PIN4) ? p4 : p3;             // [RL1]

    assign det0 = lvlDet(cr01Reg[`EIRR_B_LO_MODE], cr01Reg[`EIRR_B_LO_SUB],
                         p70, prevReg[0]);                                 // [RL6]
    assign det1 = lvlDet(cr01Reg[`EIRR_B_HI_MODE], cr01Reg[`EIRR_B_HI_SUB],
                         p7, prevReg[1]);                                  // [RL5]
    assign det2 = edgDet(cr23Reg[`EIRR_B_LO_MODE], cr23Reg[`EIRR_B_LO_SUB],
                         p6, prevReg[2], holdMode, hold2Lvl);              // [RL10] [RL13]
    assign det3 = edgDet(cr23Reg[`EIRR_B_HI_MODE], cr23Reg[`EIRR_B_HI_SUB],
                         ch3Filt, prevReg[3], 1'b0, 1'b0);                 // [RL10]
    assign det4 = edgDet(cr45Reg[`EIRR_B_LO_MODE], cr45Reg[`EIRR_B_LO_SUB],
                         ch4Pin, prevReg[4], holdMode, hold4Lvl);          // [RL21] [RL22]

    // Capture routing: ch4 capture use masks the port-7 and port-1 sources
    wire ch4CapL = (sl45Reg[1:0] == `EIRR_F4_CAPL);
    wire ch4CapH = (sl45Reg[1:0] == `EIRR_F4_CAPH);
    wire ch4Cap  = ch4CapL | ch4CapH;
    wire capLSrc = islReg[`EIRR_B_CAPL] ? (det0 & ~ch4Cap) : (det2 & ~ch4Cap); // [RL15] [RL3] [RL20]
    wire capHSrc = islReg[`EIRR_B_CAPH] ? (det1 & ~ch4Cap) : (det3 & ~ch4Cap); // [RL14] [RL20]

    wire [15:0] wrAddr = address;
    wire        wrHit  = write & ~ackReg;
    wire        hit01  = wrHit & (wrAddr == `EIRR_OFS_CR01);
    wire        hit23  = wrHit & (wrAddr == `EIRR_OFS_CR23);
    wire        hit45  = wrHit & (wrAddr == `EIRR_OFS_CR45);

    // One wait cycle, ack on the second
    assign waitrequest = (read | write) & ~ackReg;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cr01Reg     <= `EIRR_RST;
            cr23Reg     <= `EIRR_RST;
            islReg      <= `EIRR_RST;
            cr45Reg     <= `EIRR_RST;
            sl45Reg     <= `EIRR_RST;
            prevReg     <= 5'h00;
            hold2Lvl    <= 1'b0;
            hold4Lvl    <= 1'b0;
            holdPrevReg <= 1'b0;
            t1DivReg    <= 1'b0;
            ackReg      <= 1'b0;
            readdata    <= 8'h00;
            t0CapLow    <= 1'b0;
            t0CapHigh   <= 1'b0;
            t0CountClk  <= 1'b0;
            t1LowTick   <= 1'b0;
        end else if (ce) begin
            ackReg  <= (read | write) & ~ackReg;
            prevReg <= {ch4Pin, ch3Filt, p6, p7, p70};                    // [RL23]
            holdPrevReg <= holdMode;
            // Latch pin levels on HOLD entry
            if (holdMode & ~holdPrevReg) begin
                hold2Lvl <= p6;                                            // [RL13]
                hold4Lvl <= ch4Pin;                                        // [RL22]
            end
            if (hit01)
                cr01Reg <= writedata;
            else if (wrHit & (wrAddr == `EIRR_OFS_ISL))
                islReg <= writedata;
            else if (hit23)
                cr23Reg <= writedata;
            else if (hit45)
                cr45Reg <= writedata;
            else if (wrHit & (wrAddr == `EIRR_OFS_SL45))
                sl45Reg <= writedata;
            // Set wins over a clearing write in the same cycle
            if (det0) cr01Reg[`EIRR_B_LO_FLAG] <= 1'b1;                    // [RL8] [RL9]
            if (det1) cr01Reg[`EIRR_B_HI_FLAG] <= 1'b1;                    // [RL7] [RL9]
            if (det2) cr23Reg[`EIRR_B_LO_FLAG] <= 1'b1;                    // [RL12] [RL9]
            if (det3) cr23Reg[`EIRR_B_HI_FLAG] <= 1'b1;                    // [RL11] [RL9]
            if (det4) cr45Reg[`EIRR_B_LO_FLAG] <= 1'b1;                    // [RL22] [RL9]
            if (read & ~ackReg) begin
                case (address)
                    `EIRR_OFS_CR01: readdata <= cr01Reg;
                    `EIRR_OFS_CR23: readdata <= cr23Reg;
                    `EIRR_OFS_ISL:  readdata <= islReg;
                    `EIRR_OFS_CR45: readdata <= cr45Reg;
                    `EIRR_OFS_SL45: readdata <= sl45Reg;
                    default:        readdata <= 8'h00;
                endcase
            end
            t0CapLow   <= capLSrc | (ch4CapL & det4);                      // [RL2] [RL15]
            t0CapHigh  <= capHSrc | (ch4CapH & det4);                      // [RL2] [RL14]
            t0CountClk <= islReg[`EIRR_B_CNT] ? det3 : det2;               // [RL19]
            t1DivReg   <= t1DivReg ^ `EIRR_T1_DIV;
            if (sl45Reg[1:0] == `EIRR_F4_T1CNT)                           // [RL2]
                t1LowTick <= det4;                                         // [RL4]
            else
                t1LowTick <= t1DivReg;                                     // [RL4]
        end
    end

    wire rq0 = cr01Reg[`EIRR_B_LO_FLAG] & cr01Reg[`EIRR_B_LO_EN];          // [RL8]
    wire rq1 = cr01Reg[`EIRR_B_HI_FLAG] & cr01Reg[`EIRR_B_HI_EN];          // [RL7]
    wire rq2 = cr23Reg[`EIRR_B_LO_FLAG] & cr23Reg[`EIRR_B_LO_EN];          // [RL12]
    wire rq3 = cr23Reg[`EIRR_B_HI_FLAG] & cr23Reg[`EIRR_B_HI_EN];          // [RL11]
    wire rq4 = cr45Reg[`EIRR_B_LO_FLAG] & cr45Reg[`EIRR_B_LO_EN];          // [RL22]
    // Ch3 deliberately absent from HOLD release
    assign holdRelease = rq0 | rq1 | rq2 | rq4;                            // [RL11]
    assign irqReq      = holdRelease | rq3;

    always @* begin
        if (rq0)
            irqVector = `EIRR_VEC_CH0;
        else if (rq1)
            irqVector = `EIRR_VEC_CH1;
        else if (rq2 | rq4)
            irqVector = `EIRR_VEC_CH24;
        else if (rq3)
            irqVector = `EIRR_VEC_CH3;
        else
            irqVector = 16'h0000;
    end

    reg bclk;
    always @* begin
        case (islReg[5:4])                                                 // [RL16]
            2'h0:    bclk = subClk;
            2'h1:    bclk = clk;
            2'h2:    bclk = lowRcClk;
            default: bclk = t0PrescOut;
        endcase
    end
    assign baseTimerClk = bclk;

    always @* begin
        if (islReg[`EIRR_B_BUZ]) begin                                     // [RL17]
            timer1HighPwm = 1'b1;
            buzzerOut     = baseDivided;
        end else begin
            timer1HighPwm = timer1HighPwmIn;
            buzzerOut     = 1'b1;
        end
        pin17AltData = pin17FuncCtrl &
                       (islReg[`EIRR_B_BUZ] ? baseDivided : timer1HighPwmIn);
    end
endmodule // eirr_router

// >>> eirr_router_sva.sv
`include "eirr_regs.vh"
module eirr_router_sva (
    input logic        clk,             // Clock
    input logic        rstn,            // Reset
    input logic [15:0] address,         // Address
    input logic        read,            // Read
    input logic        write,           // Write
    input logic [7:0]  writedata,       // Write data
    input logic [7:0]  readdata,        // Read data
    input logic        waitrequest,     // Wait
    input logic        subClk,          // Source 0
    input logic        lowRcClk,        // Source 2
    input logic        t0PrescOut,      // Source 3
    input logic        baseDivided,     // Buzzer source
    input logic        timer1HighPwmIn, // Raw PWM
    input logic        baseTimerClk,    // Base clock
    input logic        buzzerOut,       // Buzzer
    input logic        timer1HighPwm,   // Gated PWM
    input logic        holdRelease,     // Release
    input logic        irqReq,          // Request
    input logic [15:0] irqVector        // Vector
);
    logic [7:0] islSh;
    logic       islWr;
    assign islWr = write && (address == `EIRR_OFS_ISL);
    // Shadow lags the design by a cycle, so checks skip INPUT_SIGNAL_SELECT writes
    always @(posedge clk or negedge rstn) begin
        if (!rstn) islSh <= 8'h00;
        else if (islWr && !waitrequest) islSh <= writedata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    vec_legal_a: assert property (irqVector inside {16'h0000, `EIRR_VEC_CH0,
        `EIRR_VEC_CH1, `EIRR_VEC_CH24, `EIRR_VEC_CH3}) else $error("bad vector");
    irq_any_a: assert property (irqReq == (irqVector != 16'h0000))
        else $error("request and vector disagree");
    ch3_no_hold_a: assert property (irqVector == `EIRR_VEC_CH3 |-> !holdRelease)
        else $error("hold release from ch3");
    hold_irq_a: assert property (holdRelease |-> irqReq) else $error("release alone");
    irq_keep_a: assert property ($fell(irqReq) |-> $past(write))
        else $error("request dropped without write");
    hold_keep_a: assert property ($fell(holdRelease) |-> $past(write))
        else $error("release dropped without write");
    bus_ack_a: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("bus answer late");
    isl_read_a: assert property (read && !waitrequest && address == `EIRR_OFS_ISL
        |-> readdata == islSh) else $error("select readback");
    base_clk_a: assert property (!islWr && islSh[5:4] != 2'h1 |-> baseTimerClk ==
        (islSh[5] ? (islSh[4] ? t0PrescOut : lowRcClk) : subClk)) else $error("base clock");
    buz_sel_a: assert property (!islWr |-> (islSh[3] ? (timer1HighPwm && buzzerOut ==
        baseDivided) : (buzzerOut && timer1HighPwm == timer1HighPwmIn))) else $error("buzzer");
endmodule // eirr_router_sva
bind eirr_router eirr_router_sva i_eirr_router_sva (.clk(clk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .subClk(subClk), .lowRcClk(lowRcClk), .t0PrescOut(t0PrescOut),
    .baseDivided(baseDivided), .timer1HighPwmIn(timer1HighPwmIn), .baseTimerClk(baseTimerClk),
    .buzzerOut(buzzerOut), .timer1HighPwm(timer1HighPwm), .holdRelease(holdRelease),
    .irqReq(irqReq), .irqVector(irqVector));

// >>> eirr_pin_model.sv
module eirr_pin_model (
    input  logic       clk,         // Cycle clock
    input  logic [5:0] lvlCmd,      // Wanted levels
    input  logic       holdReq,     // Enter HOLD
    input  logic       holdRelease, // Release request
    output logic [5:0] pins,        // Pin levels
    output logic       holdMode     // CPU in HOLD
);
    timeunit 1ns;
    timeprecision 1ns;
    logic reqQ = 1'b0;
    initial pins = 6'h3F;
    initial holdMode = 1'b0;
    // CPU enters HOLD on a fresh request and leaves it on release
    always @(posedge clk) begin
        pins <= lvlCmd;
        reqQ <= holdReq;
        if (holdRelease) holdMode <= 1'b0;
        else if (holdReq && !reqQ) holdMode <= 1'b1;
    end
endmodule // eirr_pin_model

// >>> eirr_router_tb_top.sv
`include "eirr_regs.vh"
module eirr_router_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, holdReq = 1'b0;
    logic [15:0] address = 16'h0000;
    logic [7:0]  writedata = 8'h00;
    logic [7:0]  readdata, d;
    logic        waitrequest, holdMode, baseTimerClk, buzzerOut, timer1HighPwm, holdRelease;
    logic        irqReq, t0CapLow, t0CapHigh, t0CountClk, t1LowTick;
    logic [5:0]  lvl = 6'h3F, pins, clkIn = 6'h00;
    logic [15:0] irqVector;
    int          capL = 0, capH = 0, cntC = 0, tick = 0, c0, c1, c2;
    int          err_total = 0, compares = 0, seed = 57;
    logic [7:0]  expQ[$];
    logic [15:0] regs[5] = '{`EIRR_OFS_CR01, `EIRR_OFS_CR23, `EIRR_OFS_ISL,
                             `EIRR_OFS_CR45, `EIRR_OFS_SL45};
    eirr_router i_eirr_router (.clk(clk), .rstn(rstn), .ce(1'b1), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .port1Pin3(pins[0]), .port1Pin4(pins[1]),
        .port1Pin5(pins[2]), .port1Pin6(pins[3]), .port1Pin7(pins[4]), .port7Pin0(pins[5]),
        .holdMode(holdMode), .subClk(clkIn[0]), .lowRcClk(clkIn[1]), .t0PrescOut(clkIn[2]),
        .baseDivided(clkIn[3]), .timer1HighPwmIn(clkIn[4]), .pin17FuncCtrl(clkIn[5]),
        .baseTimerClk(baseTimerClk), .buzzerOut(buzzerOut), .timer1HighPwm(timer1HighPwm),
        .pin17AltData(), .holdRelease(holdRelease), .irqReq(irqReq), .irqVector(irqVector),
        .t0CapLow(t0CapLow), .t0CapHigh(t0CapHigh), .t0CountClk(t0CountClk),
        .t1LowTick(t1LowTick));
    eirr_pin_model i_eirr_pin_model (.clk(clk), .lvlCmd(lvl), .holdReq(holdReq),
        .holdRelease(holdRelease), .pins(pins), .holdMode(holdMode));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        clkIn <= 6'($random(seed));
        capL  <= capL + t0CapLow;
        capH  <= capH + t0CapHigh;
        cntC  <= cntC + t0CountClk;
        tick  <= tick + t1LowTick;
    end
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One idle cycle between requests keeps each strobe a fresh rise
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        address   <= a;
        writedata <= v;
        write     <= wr;
        read      <= !wr;
        if (!wr) expQ.push_back(v);
        // Request stands until the rising edge that sees waitrequest low
        do @(posedge clk); while (waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic pin(input int i, input logic v);
        lvl[i] <= v;
        repeat (8) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0) check("readdata", 16'(readdata), 16'(expQ.pop_front()));
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        foreach (regs[i]) bus(0, regs[i], 8'h00);
        bus(0, 16'hFE00, 8'h00);
        repeat (4) begin
            d = 8'($random(seed));
            bus(1, `EIRR_OFS_ISL, d);
            bus(0, `EIRR_OFS_ISL, d);
        end
        bus(1, `EIRR_OFS_ISL, 8'hC1);
        bus(1, `EIRR_OFS_CR01, 8'h01);
        c0 = capL;
        pin(5, 0);
        bus(0, `EIRR_OFS_CR01, 8'h03);
        check("vector", irqVector, `EIRR_VEC_CH0);
        check("capLow", 16'(capL - c0), 16'd1);
        repeat (20) @(posedge clk);
        bus(0, `EIRR_OFS_CR01, 8'h03);
        bus(1, `EIRR_OFS_CR01, 8'h01);
        bus(0, `EIRR_OFS_CR01, 8'h01);
        pin(5, 1);
        pin(4, 0);
        bus(1, `EIRR_OFS_CR01, 8'h90);
        c1 = capH;
        pin(4, 1);
        bus(0, `EIRR_OFS_CR01, 8'hB0);
        check("vector", irqVector, `EIRR_VEC_CH1);
        check("capHigh", 16'(capH - c1), 16'd1);
        bus(1, `EIRR_OFS_CR01, 8'h00);
        bus(1, `EIRR_OFS_CR23, 8'hD0);
        c1 = capH;
        c2 = cntC;
        pin(2, 0);
        pin(2, 1);
        bus(0, `EIRR_OFS_CR23, 8'hF0);
        check("vector", irqVector, `EIRR_VEC_CH3);
        check("release", 16'(holdRelease), 16'd0);
        check("count", 16'(cntC - c2), 16'd2);
        check("capHigh", 16'(capH - c1), 16'd0);
        bus(1, `EIRR_OFS_CR23, 8'h09);
        holdReq <= 1'b1;
        repeat (4) @(posedge clk);
        pin(3, 0);
        pin(3, 1);
        bus(0, `EIRR_OFS_CR23, 8'h09);
        bus(1, `EIRR_OFS_CR23, 8'h0D);
        pin(3, 0);
        bus(0, `EIRR_OFS_CR23, 8'h0F);
        check("vector", irqVector, `EIRR_VEC_CH24);
        bus(1, `EIRR_OFS_CR23, 8'h00);
        holdReq <= 1'b0;
        pin(3, 1);
        // Low levels on both capture pins; every ch4 use is tried
        bus(1, `EIRR_OFS_CR01, 8'h44);
        pin(5, 0);
        pin(4, 0);
        for (int f = 0; f < 4; f++) begin
            bus(1, `EIRR_OFS_SL45, 8'(f));
            repeat (4) @(posedge clk);
            c0 = capL;
            c1 = capH;
            c2 = tick;
            repeat (10) @(posedge clk);
            check("capLow", 16'(capL - c0), f > 1 ? 16'd0 : 16'd10);
            check("capHigh", 16'(capH - c1), f > 1 ? 16'd0 : 16'd10);
            check("tick", 16'(tick - c2), f == 1 ? 16'd0 : 16'd5);
        end
        bus(1, `EIRR_OFS_CR01, 8'h00);
        bus(1, `EIRR_OFS_SL45, 8'h05);
        bus(1, `EIRR_OFS_CR45, 8'h09);
        c2 = tick;
        pin(0, 0);
        pin(0, 1);
        pin(1, 0);
        pin(1, 1);
        check("tick", 16'(tick - c2), 16'd1);
        bus(0, `EIRR_OFS_CR45, 8'h0B);
        check("vector", irqVector, `EIRR_VEC_CH24);
        give_verdict;
    end
endmodule // eirr_router_tb_top
